// File: inc/dmb_pkg.sv
package dmb_pkg;
  localparam int DMB_DMEM_WORDS = 64;
  localparam int DMB_DATA_W = 32;
  localparam int DMB_ADDR_W = 6;
  localparam int DMB_INSN_W = 16;
  localparam int DMB_REG_W = 3;
  localparam int DMB_PC_W = 16;
  localparam int DMB_HADDR_W = 8;
  localparam logic [7:0] DMB_OPF_LDW = 8'h0a;
  localparam logic [7:0] DMB_OPF_LDH = 8'h0f;
  localparam logic [7:0] DMB_OPF_STW = 8'h0b;
  localparam logic [7:0] DMB_OPF_STH = 8'h08;
  localparam logic [5:0] DMB_OP6_JMPR = 6'h30;
  localparam logic [5:0] DMB_OP6_JMPI = 6'h32;
  localparam logic [6:0] DMB_OP7_BLE_REG = 7'h68;
  localparam logic [4:0] DMB_OP5_BLE_IMM = 5'h1b;
  localparam logic [15:0] DMB_INSN_IRQ = 16'he000;
  localparam logic [6:0] DMB_OP7_SQRT = 7'h48;
  localparam int DMB_CLK_MHZ = 96;
  localparam int DMB_SQRT_NS = 83;
  localparam int DMB_SQRT_CYC = 8;
  localparam int DMB_SQRT_ITERS = 16;
  localparam logic [6:0] DMB_OP7_QUOT = 7'h28;
  localparam logic [6:0] DMB_OP7_ROTATE = 7'h38;
  localparam logic [6:0] DMB_OP7_POLAR = 7'h3c;
  localparam int DMB_QUOT_CYC = 10;
  localparam int DMB_TRIG_CYC = 8;
  localparam logic [31:0] DMB_RESET_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {DMB_RUN, DMB_IRQ_WAIT, DMB_HALT} dmb_state_e;
endpackage : dmb_pkg

// File: inc/dmb_hif.sv
`timescale 1ns/1ps
interface dmb_hif;
  import dmb_pkg::*;
  logic wr_en;
  logic [DMB_ADDR_W-1:0] addr;
  logic [DMB_DATA_W-1:0] wdata;
  logic [3:0] be;
  logic [DMB_ADDR_W-1:0] raddr;
  logic [DMB_DATA_W-1:0] rdata;
  modport core (output wr_en, addr, wdata, be, raddr, input rdata);
  modport port (input wr_en, addr, wdata, be, raddr, output rdata);
endinterface : dmb_hif

// File: hw/dmb_host_port.sv
`timescale 1ns/1ps
module dmb_host_port
  import dmb_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  dmb_hif.port h,
  output logic c_valid_o,
  output logic [DMB_ADDR_W-1:0] c_addr_o,
  output logic [DMB_DATA_W-1:0] c_data_o,
  output logic [3:0] c_be_o,
  input wire logic [DMB_DATA_W-1:0] arr_rdata_i
);
  logic c_valid_q, c_valid_d;
  logic [DMB_ADDR_W-1:0] c_addr_q, c_addr_d;
  logic [DMB_DATA_W-1:0] c_data_q, c_data_d;
  logic [3:0] c_be_q, c_be_d;
  logic hit;
  always_comb begin
    c_valid_d = c_valid_q;
    c_addr_d = c_addr_q;
    c_data_d = c_data_q;
    c_be_d = c_be_q;
    if (h.wr_en) begin
      c_valid_d = 1'b1;
      c_addr_d = h.addr;
      if (c_valid_q && c_addr_q == h.addr) begin
        for (int i = 0; i < 4; i++) begin
          if (h.be[i]) begin
            c_data_d[8*i +: 8] = h.wdata[8*i +: 8];
          end
        end
        c_be_d = c_be_q | h.be;
      end else begin
        c_data_d = h.wdata;
        c_be_d = h.be;
      end
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      c_valid_q <= 1'b0;
      c_addr_q <= '0;
      c_data_q <= DMB_RESET_WORD;
      c_be_q <= 4'h0;
    end else begin
      c_valid_q <= c_valid_d;
      c_addr_q <= c_addr_d;
      c_data_q <= c_data_d;
      c_be_q <= c_be_d;
    end
  end
  // Flush old word only when a new address is written
  assign c_valid_o = h.wr_en && c_valid_q && (c_addr_q != h.addr);
  assign c_addr_o = c_addr_q;
  assign c_data_o = c_data_q;
  assign c_be_o = c_be_q;
  assign hit = c_valid_q && (c_addr_q == h.raddr);
  always_comb begin
    h.rdata = arr_rdata_i;
    if (hit) begin
      for (int i = 0; i < 4; i++) begin
        if (c_be_q[i]) begin
          h.rdata[8*i +: 8] = c_data_q[8*i +: 8];
        end
      end
    end
  end
endmodule : dmb_host_port

// File: hw/dmb_core.sv
`timescale 1ns/1ps
module dmb_core
  import dmb_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [DMB_INSN_W-1:0] insn_i,
  input wire logic insn_valid_i,
  output logic [DMB_PC_W-1:0] pc_o,
  output logic stall_o,
  output logic irq_o,
  input wire logic irq_ack_i,
  output logic sqrt_busy_o,
  output logic reserved_o,
  input wire logic [DMB_REG_W-1:0] rd_sel_i,
  output logic [DMB_DATA_W-1:0] rd_data_o,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [DMB_HADDR_W-1:0] host_addr_i,
  input wire logic [DMB_DATA_W-1:0] host_wdata_i,
  input wire logic [3:0] host_be_i,
  output logic [DMB_DATA_W-1:0] host_rdata_o
);
  logic [DMB_DATA_W-1:0] dmem [DMB_DMEM_WORDS];
  logic [DMB_DATA_W-1:0] regs_q [8];
  logic [DMB_DATA_W-1:0] regs_d [8];
  logic [DMB_PC_W-1:0] pc_q, pc_d;
  dmb_state_e st_q, st_d;
  logic st_pend_q, st_pend_d;
  logic [DMB_ADDR_W-1:0] st_addr_q, st_addr_d;
  logic [DMB_REG_W-1:0] st_src_q, st_src_d;
  logic sq_busy_q, sq_busy_d;
  logic [3:0] sq_cnt_q, sq_cnt_d;
  logic [DMB_REG_W-1:0] sq_dst_q, sq_dst_d;
  logic [DMB_DATA_W-1:0] sq_rem_q, sq_rem_d;
  logic [15:0] sq_root_q, sq_root_d;
  logic [DMB_DATA_W-1:0] sq_src_q, sq_src_d;
  logic reserved_q, reserved_d;
  logic lp_busy_q, lp_busy_d;
  logic [3:0] lp_cnt_q, lp_cnt_d;
  logic [DMB_DATA_W-1:0] host_rdata_q;
  logic c_valid;
  logic [DMB_ADDR_W-1:0] c_addr;
  logic [DMB_DATA_W-1:0] c_data;
  logic [3:0] c_be;
  logic [DMB_DATA_W-1:0] arr_rdata;
  dmb_hif hif ();

  function automatic logic [DMB_DATA_W-1:0] sext16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction : sext16

  function automatic logic [DMB_DATA_W-1:0] rf(input logic [DMB_REG_W-1:0] s,
                                                input logic [DMB_DATA_W-1:0] r [8]);
    return (s == 3'd0) ? '0 : r[s];
  endfunction : rf

  function automatic logic [DMB_PC_W-1:0] rel(input logic [DMB_PC_W-1:0] p,
                                              input logic [DMB_PC_W-1:0] off);
    return p + 16'd1 + off;
  endfunction : rel

  // Background occupancy minus one; zero for anything else
  function automatic logic [3:0] lp_len(input logic [DMB_INSN_W-1:0] i);
    logic [3:0] n;
    n = 4'd0;
    if (i[15:9] == DMB_OP7_QUOT) begin
      n = 4'(DMB_QUOT_CYC - 1);
    end else if (i[15:9] == DMB_OP7_ROTATE || i[15:9] == DMB_OP7_POLAR) begin
      n = 4'(DMB_TRIG_CYC - 1);
    end
    return n;
  endfunction : lp_len

  // Word index from host byte address
  assign hif.wr_en = host_wr_i;
  assign hif.addr = host_addr_i[DMB_HADDR_W-1:2];
  assign hif.wdata = host_wdata_i;
  assign hif.be = host_be_i;
  assign hif.raddr = host_addr_i[DMB_HADDR_W-1:2];
  assign arr_rdata = dmem[host_addr_i[DMB_HADDR_W-1:2]];

  dmb_host_port u_port (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .h(hif.port),
    .c_valid_o(c_valid),
    .c_addr_o(c_addr),
    .c_data_o(c_data),
    .c_be_o(c_be),
    .arr_rdata_i(arr_rdata)
  );

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_rdata_q <= '0;
    end else if (host_rd_i) begin
      host_rdata_q <= hif.rdata;
    end
  end
  assign host_rdata_o = host_rdata_q;

  // Decode and execute
  always_comb begin
    logic [2:0] ra, rb, rc;
    logic le;
    logic [DMB_DATA_W-1:0] reg_off;
    logic [DMB_DATA_W-1:0] rem;
    logic [15:0] root;
    logic [DMB_DATA_W-1:0] src;
    logic [DMB_DATA_W-1:0] trial;
    ra = insn_i[2:0];
    rb = insn_i[5:3];
    rc = insn_i[8:6];
    le = $signed(rf(ra, regs_q)) <= $signed(rf(rb, regs_q));
    reg_off = rf(rc, regs_q);
    rem = sq_rem_q;
    root = sq_root_q;
    src = sq_src_q;
    trial = '0;
    for (int i = 0; i < 8; i++) begin
      regs_d[i] = regs_q[i];
    end
    pc_d = pc_q;
    st_d = st_q;
    st_pend_d = 1'b0;
    st_addr_d = st_addr_q;
    st_src_d = st_src_q;
    reserved_d = 1'b0;
    sq_busy_d = sq_busy_q;
    sq_cnt_d = sq_cnt_q;
    sq_dst_d = sq_dst_q;
    sq_rem_d = sq_rem_q;
    sq_root_d = sq_root_q;
    sq_src_d = sq_src_q;
    lp_busy_d = lp_busy_q;
    lp_cnt_d = lp_cnt_q;
    // Divide and trig results belong elsewhere; only their pipe slot is kept here
    if (lp_busy_q) begin
      lp_cnt_d = lp_cnt_q - 4'd1;
      if (lp_cnt_q == 4'd0) begin
        lp_busy_d = 1'b0;
      end
    end
    // Two root bits per cycle, done in eight
    if (sq_busy_q) begin
      for (int k = 0; k < 2; k++) begin
        rem = {rem[29:0], src[31:30]};
        src = {src[29:0], 2'b00};
        trial = {14'd0, root, 2'b01};
        if (rem >= trial) begin
          rem = rem - trial;
          root = {root[14:0], 1'b1};
        end else begin
          root = {root[14:0], 1'b0};
        end
      end
      sq_rem_d = rem;
      sq_root_d = root;
      sq_src_d = src;
      sq_cnt_d = sq_cnt_q + 4'd1;
      if (sq_cnt_q == 4'(DMB_SQRT_CYC - 1)) begin
        sq_busy_d = 1'b0;
      end
    end
    case (st_q)
      DMB_RUN: begin
        if (insn_valid_i) begin
          pc_d = pc_q + 16'd1;
          if (insn_i[15:12] == DMB_OPF_LDW[3:0]) begin
            regs_d[rb] = dmem[insn_i[11:6]];
          end else if (insn_i[15:12] == DMB_OPF_LDH[3:0]) begin
            regs_d[rb] = sext16(dmem[insn_i[11:6]][31:16]);
            regs_d[ra] = sext16(dmem[insn_i[11:6]][15:0]);
          end else if (insn_i[15:12] == DMB_OPF_STW[3:0]) begin
            st_pend_d = 1'b1;
            st_addr_d = insn_i[11:6];
            st_src_d = ra;
          end else if (insn_i[15:12] == DMB_OPF_STH[3:0]) begin
            reserved_d = 1'b1;
          end else if (insn_i[15:10] == DMB_OP6_JMPI) begin
            pc_d = rel(pc_q, {{6{insn_i[9]}}, insn_i[9:0]});
          end else if (insn_i[15:10] == DMB_OP6_JMPR) begin
            reserved_d = 1'b1;
          end else if (insn_i[15:9] == DMB_OP7_BLE_REG) begin
            if (le) begin
              pc_d = rel(pc_q, reg_off[15:0]);
            end
          end else if (insn_i[15:11] == DMB_OP5_BLE_IMM) begin
            if (le) begin
              pc_d = rel(pc_q, {{11{insn_i[10]}}, insn_i[10:6]});
            end
          end else if (insn_i == DMB_INSN_IRQ) begin
            st_d = DMB_IRQ_WAIT;
          end else if (lp_len(insn_i) != 4'd0) begin
            if (!sq_busy_q && !lp_busy_q) begin
              lp_busy_d = 1'b1;
              lp_cnt_d = lp_len(insn_i);
            end
          end else if (insn_i[15:9] == DMB_OP7_SQRT && !sq_busy_q && !lp_busy_q) begin
            sq_busy_d = 1'b1;
            sq_cnt_d = '0;
            sq_dst_d = rb;
            sq_rem_d = '0;
            sq_root_d = '0;
            sq_src_d = rf(ra, regs_q);
          end
        end
      end
      DMB_IRQ_WAIT: begin
        if (irq_ack_i) begin
          st_d = DMB_RUN;
        end
      end
      default: st_d = DMB_RUN;
    endcase
    if (sq_busy_q && !sq_busy_d) begin
      regs_d[sq_dst_q] = {16'd0, sq_root_d};
    end
    regs_d[0] = '0;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= '0;
      end
      pc_q <= '0;
      st_q <= DMB_RUN;
      st_pend_q <= 1'b0;
      st_addr_q <= '0;
      st_src_q <= '0;
      reserved_q <= 1'b0;
      sq_busy_q <= 1'b0;
      sq_cnt_q <= '0;
      sq_dst_q <= '0;
      sq_rem_q <= '0;
      sq_root_q <= '0;
      sq_src_q <= '0;
      lp_busy_q <= 1'b0;
      lp_cnt_q <= '0;
    end else begin
      regs_q <= regs_d;
      pc_q <= pc_d;
      st_q <= st_d;
      st_pend_q <= st_pend_d;
      st_addr_q <= st_addr_d;
      st_src_q <= st_src_d;
      reserved_q <= reserved_d;
      sq_busy_q <= sq_busy_d;
      sq_cnt_q <= sq_cnt_d;
      sq_dst_q <= sq_dst_d;
      sq_rem_q <= sq_rem_d;
      sq_root_q <= sq_root_d;
      sq_src_q <= sq_src_d;
      lp_busy_q <= lp_busy_d;
      lp_cnt_q <= lp_cnt_d;
    end
  end

  // Memory array; flush and store both land, store last so it wins on one word
  always_ff @(posedge clk_i) begin
    if (c_valid) begin
      for (int i = 0; i < 4; i++) begin
        if (c_be[i]) begin
          dmem[c_addr][8*i +: 8] <= c_data[8*i +: 8];
        end
      end
    end
    if (st_pend_q) begin
      dmem[st_addr_q] <= rf(st_src_q, regs_q);
    end
  end

  assign pc_o = pc_q;
  assign stall_o = (st_q != DMB_RUN);
  assign irq_o = (st_q == DMB_IRQ_WAIT);
  assign sqrt_busy_o = sq_busy_q;
  assign reserved_o = reserved_q;
  assign rd_data_o = regs_q[rd_sel_i];
endmodule : dmb_core

// File: testbench/dmb_core_chk.sv
`timescale 1ns/1ps
module dmb_core_chk
  import dmb_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [DMB_INSN_W-1:0] insn_i,
  input wire logic insn_valid_i,
  input wire logic [DMB_PC_W-1:0] pc_o,
  input wire logic stall_o,
  input wire logic irq_o,
  input wire logic irq_ack_i,
  input wire logic sqrt_busy_o,
  input wire logic reserved_o
);
  logic tk;
  int lp_left;
  assign tk = insn_valid_i && !stall_o;
  // Background pipe occupancy as the instruction stream implies it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lp_left <= 0;
    end else if (tk && !sqrt_busy_o && lp_left == 0 && insn_i[15:9] == DMB_OP7_QUOT) begin
      lp_left <= DMB_QUOT_CYC;
    end else if (tk && !sqrt_busy_o && lp_left == 0 &&
                 (insn_i[15:9] == DMB_OP7_ROTATE || insn_i[15:9] == DMB_OP7_POLAR)) begin
      lp_left <= DMB_TRIG_CYC;
    end else if (lp_left > 0) begin
      lp_left <= lp_left - 1;
    end
  end
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  irq_raise_a: assert property (tk && insn_i == DMB_INSN_IRQ |=> irq_o && stall_o)
    else $error("irq not raised");
  irq_hold_a: assert property (irq_o && !irq_ack_i |=> irq_o)
    else $error("irq dropped early");
  halt_pc_a: assert property (stall_o |=> $stable(pc_o))
    else $error("pc moved while halted");
  sqrt_start_a: assert property (tk && insn_i[15:9] == DMB_OP7_SQRT &&
    !sqrt_busy_o && lp_left == 0 |=> sqrt_busy_o)
    else $error("sqrt not started");
  pipe_block_a: assert property (tk && insn_i[15:9] == DMB_OP7_SQRT &&
    !sqrt_busy_o && lp_left != 0 |=> !sqrt_busy_o)
    else $error("sqrt issued over long op");
  sqrt_bound_a: assert property ($rose(sqrt_busy_o) |-> ##[1:8] !sqrt_busy_o)
    else $error("sqrt too slow");
  jump_pc_a: assert property (tk && insn_i[15:10] == DMB_OP6_JMPI |=>
    pc_o == $past(pc_o) + 16'd1 + {{6{$past(insn_i[9])}}, $past(insn_i[9:0])})
    else $error("bad jump target");
  resv_flag_a: assert property (tk && (insn_i[15:10] == DMB_OP6_JMPR ||
    insn_i[15:12] == DMB_OPF_STH[3:0]) |=> reserved_o)
    else $error("reserved op not flagged");
  step_pc_a: assert property (tk && insn_i[15:12] == DMB_OPF_LDW[3:0]
    |=> pc_o == $past(pc_o) + 16'd1)
    else $error("pc not stepped");
endmodule : dmb_core_chk

bind dmb_core dmb_core_chk u_dmb_core_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .insn_i(insn_i), .insn_valid_i(insn_valid_i), .pc_o(pc_o), .stall_o(stall_o),
  .irq_o(irq_o), .irq_ack_i(irq_ack_i), .sqrt_busy_o(sqrt_busy_o), .reserved_o(reserved_o));

// File: testbench/dmb_host_svc.sv
`timescale 1ns/1ps
module dmb_host_svc #(parameter int DLY = 6) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic irq_i,
  output logic irq_ack_o
);
  int cnt;
  // Service delay, then a one-cycle acknowledge
  always @(negedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 0;
      irq_ack_o <= 1'b0;
    end else begin
      irq_ack_o <= irq_i && cnt == DLY;
      cnt <= (irq_i && cnt < DLY) ? cnt + 1 : 0;
    end
  end
endmodule : dmb_host_svc

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dmb_pkg::*;
  logic clk_i, arst_n_i, insn_valid_i, irq_ack_i, host_wr_i, host_rd_i, got_rd;
  logic stall_o, irq_o, sqrt_busy_o, reserved_o;
  logic [15:0] insn_i, pc_o, p;
  logic [7:0] host_addr_i;
  logic [3:0] host_be_i;
  logic [2:0] rd_sel_i;
  logic [31:0] rd_data_o, host_wdata_i, host_rdata_o, v, w;
  logic [31:0] exp_q[$];
  int err_total, n_checks;
  logic [6:0] lop [3];
  int lcy [3];
  dmb_core u_dmb_core (.clk_i(clk_i), .arst_n_i(arst_n_i), .insn_i(insn_i),
    .insn_valid_i(insn_valid_i), .pc_o(pc_o), .stall_o(stall_o), .irq_o(irq_o),
    .irq_ack_i(irq_ack_i), .sqrt_busy_o(sqrt_busy_o), .reserved_o(reserved_o),
    .rd_sel_i(rd_sel_i), .rd_data_o(rd_data_o), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i),
    .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i), .host_be_i(host_be_i),
    .host_rdata_o(host_rdata_o));
  dmb_host_svc u_dmb_host_svc (.clk_i(clk_i), .arst_n_i(arst_n_i), .irq_i(irq_o),
    .irq_ack_o(irq_ack_i));
  task automatic stop_test();
    if (exp_q.size() != 0) err_total++;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic ex(input logic [15:0] i);
    @(negedge clk_i);
    insn_i = i;
    insn_valid_i = 1'b1;
    @(negedge clk_i);
    insn_valid_i = 1'b0;
  endtask : ex
  task automatic peek(input logic [2:0] s, input logic [31:0] e);
    rd_sel_i = s;
    #1;
    chk(rd_data_o, e);
  endtask : peek
  task automatic hw(input logic [5:0] a, input logic [31:0] d, input logic [3:0] b);
    @(negedge clk_i);
    host_wr_i = 1'b1;
    host_addr_i = {a, 2'b00};
    host_wdata_i = d;
    host_be_i = b;
    @(negedge clk_i);
    host_wr_i = 1'b0;
  endtask : hw
  task automatic hr(input logic [5:0] a, input logic [31:0] e);
    @(negedge clk_i);
    host_rd_i = 1'b1;
    host_addr_i = {a, 2'b00};
    exp_q.push_back(e);
    @(negedge clk_i);
    host_rd_i = 1'b0;
  endtask : hr
  task automatic br(input logic [15:0] i, input logic [15:0] off);
    p = pc_o + 16'd1 + off;
    ex(i);
    chk({16'h0000, pc_o}, {16'h0000, p});
  endtask : br
  always @(posedge clk_i) got_rd <= host_rd_i;
  always @(negedge clk_i) begin
    if (got_rd === 1'b1 && exp_q.size() > 0) chk(host_rdata_o, exp_q.pop_front());
  end
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    stop_test();
  end
  initial begin
    {insn_i, insn_valid_i, rd_sel_i, host_wr_i, host_rd_i, host_addr_i} = '0;
    {host_wdata_i, host_be_i} = '0;
    lop = '{DMB_OP7_QUOT, DMB_OP7_ROTATE, DMB_OP7_POLAR};
    lcy = '{DMB_QUOT_CYC, DMB_TRIG_CYC, DMB_TRIG_CYC};
    arst_n_i = 1'b0;
    v = $urandom(32'h07e7_63ac);
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    arst_n_i = 1'b1;
    chk({29'h0, irq_o, stall_o, sqrt_busy_o}, 32'h0);
    v = $urandom;
    w = $urandom;
    hw(6'd63, v, 4'hf);
    hr(6'd63, v);
    hw(6'd1, 32'h8001_7ffe, 4'hf);
    hw(6'd2, w, 4'hf);
    hw(6'd5, w, 4'hf);
    hw(6'd2, 32'h0000_00a5, 4'h1);
    hw(6'd5, 32'h1234_0000, 4'hc);
    hw(6'd3, 32'h0000_0090, 4'hf);
    hw(6'd4, 32'h0000_0000, 4'hf);
    hr(6'd2, {w[31:8], 8'ha5});
    hr(6'd5, {16'h1234, w[15:0]});
    ex({DMB_OPF_LDW[3:0], 6'd63, 3'd1, 3'd0});
    peek(3'd1, v);
    ex({DMB_OPF_LDH[3:0], 6'd1, 3'd2, 3'd3});
    peek(3'd2, 32'hffff_8001);
    peek(3'd3, 32'h0000_7ffe);
    ex({DMB_OPF_STW[3:0], 6'd10, 3'd0, 3'd1});
    ex(16'h0000);
    ex({DMB_OPF_LDW[3:0], 6'd10, 3'd4, 3'd0});
    peek(3'd4, v);
    hr(6'd10, v);
    hw(6'd11, w, 4'hf);
    hw(6'd12, w, 4'hf);
    ex({DMB_OPF_STW[3:0], 6'd11, 3'd0, 3'd1});
    ex({DMB_OPF_STW[3:0], 6'd12, 3'd0, 3'd1});
    hr(6'd11, v);
    hr(6'd12, w);
    repeat (4) begin
      w = $urandom;
      br({DMB_OP6_JMPI, w[9:0]}, {{6{w[9]}}, w[9:0]});
    end
    br({DMB_OP7_BLE_REG, 3'd3, 3'd3, 3'd0}, 16'h7ffe);
    br({DMB_OP7_BLE_REG, 3'd3, 3'd0, 3'd3}, 16'h0000);
    br({DMB_OP7_BLE_REG, 3'd0, 3'd3, 3'd3}, 16'h0000);
    br({DMB_OP5_BLE_IMM, 5'h10, 3'd3, 3'd0}, 16'hfff0);
    br({DMB_OP5_BLE_IMM, 5'h07, 3'd0, 3'd3}, 16'h0000);
    ex({DMB_OP6_JMPR, 10'h001});
    chk({31'h0, reserved_o}, 32'h1);
    ex({DMB_OPF_STH[3:0], 6'd10, 3'd2, 3'd3});
    chk({31'h0, reserved_o}, 32'h1);
    hr(6'd10, v);
    ex(DMB_INSN_IRQ);
    chk({30'h0, irq_o, stall_o}, 32'h3);
    p = pc_o;
    ex({DMB_OP6_JMPI, 10'h005});
    chk({16'h0000, pc_o}, {16'h0000, p});
    for (int n = 0; n < 20 && stall_o !== 1'b0; n++) @(negedge clk_i);
    chk({31'h0, stall_o}, 32'h0);
    // Root issued on the last busy slot is dropped, two cycles later it starts
    foreach (lop[k]) begin
      ex({lop[k], 9'h000});
      repeat (lcy[k] - 2) @(negedge clk_i);
      ex({DMB_OP7_SQRT, 3'd0, 3'd6, 3'd5});
      chk({31'h0, sqrt_busy_o}, 32'h0);
      ex({DMB_OP7_SQRT, 3'd0, 3'd6, 3'd5});
      chk({31'h0, sqrt_busy_o}, 32'h1);
      repeat (8) @(negedge clk_i);
    end
    ex({DMB_OPF_LDW[3:0], 6'd3, 3'd5, 3'd0});
    ex({DMB_OP7_SQRT, 3'd0, 3'd6, 3'd5});
    ex({DMB_OPF_LDW[3:0], 6'd63, 3'd6, 3'd0});
    peek(3'd6, v);
    chk({31'h0, sqrt_busy_o}, 32'h1);
    repeat (6) @(negedge clk_i);
    peek(3'd6, 32'h0000_000c);
    stop_test();
  end
endmodule : testbench
